// [core/rpc_edge_sync.v]
/*
  Two-flop synchroniser with a registered rising edge detector.
  Assumes i_lvl is asynchronous to i_clk and changes slower than i_clk / 4.
*/
`timescale 1ns/1ps
module rpc_edge_sync (
  input  wire i_clk,
  input  wire i_arst_n,
  input  wire i_lvl,
  output reg  o_rise
);
  reg meta_q;
  reg sync_q;
  reg prev_q;

  // first flop feeds only the second; edge taken from second and third
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      o_rise <= 1'b0;
    end else begin
      meta_q <= i_lvl;
      sync_q <= meta_q;
      prev_q <= sync_q;
      o_rise <= sync_q & ~prev_q;
    end
  end
endmodule // rpc_edge_sync

// [core/rpc_fifo_clk.v]
/*
  Receive phase compensation FIFO with write and read clock selection.
  The link clocks arrive as pins slower than a quarter of i_clk; each is
  synchronised and its rising edges act as write or read strobes.
  Assumes software sets the configuration before setting the enable bit.
*/
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "rpc_map.vh"
module rpc_fifo_clk (
  input  wire                    i_clk,
  input  wire                    i_arst_n,
  input  wire [`RPC_ADDR_W-1:0]  i_addr,
  input  wire [`RPC_BUS_W-1:0]   i_wdata,
  input  wire                    i_wr,
  input  wire                    i_rd,
  output reg  [`RPC_BUS_W-1:0]   o_rdata,
  input  wire                    i_tx_pclk,
  input  wire                    i_rx_pclk,
  input  wire                    i_core_clk_x4,
  input  wire                    i_core_clk_x8,
  input  wire                    i_user_rdclk,
  input  wire [`RPC_DATA_W-1:0]  i_rx_data,
  input  wire [`RPC_STAT_W-1:0]  i_rx_status,
  output reg  [`RPC_DATA_W-1:0]  o_rd_data,
  output reg  [`RPC_STAT_W-1:0]  o_rd_status,
  output reg                     o_rd_valid,
  output reg                     o_fifo_err
);
  localparam [`RPC_ACT_W-1:0] ACT_TMO = `RPC_ACT_TMO_CYC;
  localparam [`RPC_AW:0]      DEPTH   = {1'b1, {`RPC_AW{1'b0}}};

  // control and sticky state
  reg  [`RPC_CTRL_W-1:0]  ctrl_q;
  reg                     ovf_q;
  reg                     unf_q;
  // synchronised input word
  reg  [`RPC_DATA_W-1:0]  dat_meta_q;
  reg  [`RPC_DATA_W-1:0]  dat_sync_q;
  reg  [`RPC_STAT_W-1:0]  st_meta_q;
  reg  [`RPC_STAT_W-1:0]  st_sync_q;
  // storage and pointers
  reg  [`RPC_DATA_W+`RPC_STAT_W-1:0] mem_q [0:`RPC_DEPTH-1];
  reg  [`RPC_AW:0]        wptr_q;
  reg  [`RPC_AW:0]        rptr_q;
  // byte deserializer dividers for each side
  reg                     wdiv_q;
  reg                     rdiv_q;
  // clock activity watchdogs
  reg  [`RPC_ACT_W-1:0]   wact_cnt_q;
  reg  [`RPC_ACT_W-1:0]   ract_cnt_q;
  // selected sources, shown in status
  reg  [2:0]              wsel_d;
  reg  [2:0]              rsel_d;
  reg  [2:0]              wsel_q;
  reg  [2:0]              rsel_q;
  reg  [`RPC_BUS_W-1:0]   rdata_d;

  wire [`RPC_NCLK-1:0]    clk_lvl;
  wire [`RPC_NCLK-1:0]    clk_rise;
  wire [1:0]              bond;
  wire                    rmatch;
  wire                    bdeser;
  wire                    user_rd;
  wire                    enable;
  wire                    wedge;
  wire                    redge;
  wire                    do_wr;
  wire                    do_rd;
  wire                    wr_try;
  wire                    rd_try;
  wire                    full;
  wire                    empty;
  wire [`RPC_AW:0]        level;
  wire                    st_wr;
  wire [`RPC_BUS_W-1:0]   status;

  assign clk_lvl = {i_user_rdclk, i_core_clk_x8, i_core_clk_x4, i_rx_pclk, i_tx_pclk};

  // one synchroniser and edge detector per incoming clock
  genvar g;
  generate
    for (g = 0; g < `RPC_NCLK; g = g + 1) begin : g_clk
      rpc_edge_sync u_sync (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_lvl    (clk_lvl[g]),
        .o_rise   (clk_rise[g])
      );
    end
  endgenerate

  assign bond    = ctrl_q[`RPC_CTRL_BOND_HI:`RPC_CTRL_BOND_LO];
  assign rmatch  = ctrl_q[`RPC_CTRL_RMATCH];
  assign bdeser  = ctrl_q[`RPC_CTRL_BDESER];
  assign user_rd = ctrl_q[`RPC_CTRL_USERRD];
  assign enable  = ctrl_q[`RPC_CTRL_ENABLE];

  // write clock choice follows bonding and rate matcher
  always @* begin
    case (bond)
      `RPC_BOND_X4: wsel_d = `RPC_SRC_CORE4;             // [R3]
      `RPC_BOND_X8: wsel_d = `RPC_SRC_CORE8;             // [R4]
      default: begin
        if (rmatch) begin
          wsel_d = `RPC_SRC_TX;                          // [R1]
        end else begin
          wsel_d = `RPC_SRC_RX;                          // [R2]
        end
      end
    endcase
  end

  // read clock: user input when enabled, else same source as the write side
  always @* begin
    if (user_rd) begin
      rsel_d = `RPC_SRC_USER;                            // [R10] [R9]
    end else begin
      rsel_d = wsel_d;                                   // [R11]
    end
  end

  assign wedge = clk_rise[wsel_q];
  assign redge = clk_rise[rsel_q];

  // register the selections so the edge mux has a stable select
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wsel_q <= `RPC_SRC_TX;
      rsel_q <= `RPC_SRC_TX;
    end else begin
      wsel_q <= wsel_d;
      rsel_q <= rsel_d;
    end
  end

  // halve the write clock under the byte deserializer
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wdiv_q <= 1'b0;
    end else if (!enable || !bdeser) begin
      wdiv_q <= 1'b0;
    end else if (wedge) begin
      wdiv_q <= ~wdiv_q;                                 // [R5]
    end
  end

  // automatic read clock is halved too; the user clock is taken as given
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdiv_q <= 1'b0;
    end else if (!enable || !bdeser || user_rd) begin
      rdiv_q <= 1'b0;
    end else if (redge) begin
      rdiv_q <= ~rdiv_q;                                 // [R11]
    end
  end

  assign wr_try = enable & wedge & (~bdeser | wdiv_q);   // [R5]
  assign rd_try = enable & redge & (~bdeser | user_rd | rdiv_q);

  // capture incoming word through two flops, like the clocks
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dat_meta_q <= {`RPC_DATA_W{1'b0}};
      dat_sync_q <= {`RPC_DATA_W{1'b0}};
      st_meta_q  <= {`RPC_STAT_W{1'b0}};
      st_sync_q  <= {`RPC_STAT_W{1'b0}};
    end else begin
      dat_meta_q <= i_rx_data;
      dat_sync_q <= dat_meta_q;
      st_meta_q  <= i_rx_status;
      st_sync_q  <= st_meta_q;
    end
  end

  assign level = wptr_q - rptr_q;
  assign full  = (level == DEPTH);
  assign empty = (level == {(`RPC_AW+1){1'b0}});
  assign do_wr = wr_try & ~full;
  assign do_rd = rd_try & ~empty;

  // storage array; a full FIFO drops the incoming word
  always @(posedge i_clk) begin
    if (do_wr) begin
      mem_q[wptr_q[`RPC_AW-1:0]] <= {st_sync_q, dat_sync_q}; // [R12]
    end
  end

  // pointers advance in strict order; clearing enable flushes both
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wptr_q <= {(`RPC_AW+1){1'b0}};
      rptr_q <= {(`RPC_AW+1){1'b0}};
    end else if (!enable) begin
      wptr_q <= {(`RPC_AW+1){1'b0}};
      rptr_q <= {(`RPC_AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wptr_q <= wptr_q + 1'b1;                         // [R12]
      end
      if (do_rd) begin
        rptr_q <= rptr_q + 1'b1;                         // [R12]
      end
    end
  end

  // read side output, one strobe per word popped
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data   <= {`RPC_DATA_W{1'b0}};
      o_rd_status <= {`RPC_STAT_W{1'b0}};
      o_rd_valid  <= 1'b0;
    end else begin
      o_rd_valid <= do_rd;                               // [R12]
      if (do_rd) begin
        {o_rd_status, o_rd_data} <= mem_q[rptr_q[`RPC_AW-1:0]];
      end
    end
  end

  assign st_wr = i_wr && (i_addr == `RPC_OFF_STATUS);

  // sticky mismatch flags; a new event wins over a write-one clear
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end else begin
      if (wr_try && full) begin
        ovf_q <= 1'b1;                                   // [R7] [R6]
      end else if (st_wr && i_wdata[`RPC_ST_OVF]) begin
        ovf_q <= 1'b0;
      end
      if (rd_try && empty && !do_wr) begin  // same-edge push is no starve
        unf_q <= 1'b1;                                   // [R7] [R6]
      end else if (st_wr && i_wdata[`RPC_ST_UNF]) begin
        unf_q <= 1'b0;
      end
    end
  end

  // error output raised while either flag stands
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_fifo_err <= 1'b0;
    end else begin
      o_fifo_err <= ovf_q | unf_q;                       // [R7]
    end
  end

  // watchdogs: a selected clock with no edge for the timeout reads idle
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wact_cnt_q <= {`RPC_ACT_W{1'b0}};
      ract_cnt_q <= {`RPC_ACT_W{1'b0}};
    end else begin
      if (wedge) begin
        wact_cnt_q <= ACT_TMO;
      end else if (wact_cnt_q != {`RPC_ACT_W{1'b0}}) begin
        wact_cnt_q <= wact_cnt_q - 1'b1;
      end
      if (redge) begin
        ract_cnt_q <= ACT_TMO;                           // [R8]
      end else if (ract_cnt_q != {`RPC_ACT_W{1'b0}}) begin
        ract_cnt_q <= ract_cnt_q - 1'b1;
      end
    end
  end

  // control register write
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= `RPC_CTRL_RST;
    end else if (i_wr && (i_addr == `RPC_OFF_CTRL)) begin
      ctrl_q <= i_wdata[`RPC_CTRL_W-1:0];
    end
  end

  // status word assembled from live state
  assign status = {12'h000,
                   1'b0, rsel_q,
                   1'b0, wsel_q,
                   level,
                   2'h0,
                   (ract_cnt_q != {`RPC_ACT_W{1'b0}}),
                   (wact_cnt_q != {`RPC_ACT_W{1'b0}}),
                   empty, full, unf_q, ovf_q};

  // read mux; unmapped addresses read zero
  always @* begin
    case (i_addr)
      `RPC_OFF_CTRL:   rdata_d = {{(`RPC_BUS_W-`RPC_CTRL_W){1'b0}}, ctrl_q};
      `RPC_OFF_STATUS: rdata_d = status;
      default:         rdata_d = {`RPC_BUS_W{1'b0}};
    endcase
  end

  // read data stand for the one cycle after the strobe
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= {`RPC_BUS_W{1'b0}};
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= {`RPC_BUS_W{1'b0}};
    end
  end
endmodule // rpc_fifo_clk

// [core/rpc_map.vh]
/*
  Constants for the receive phase compensation FIFO and its clock selection:
  register offsets, field positions, reset values, sizes and timing counts.
  Assumes inclusion by the design files only; holds definitions and nothing else.
*/
// Contract
// [R1] non-bonded with rate matcher: write on transmit clock
// [R2] non-bonded without rate matcher: write on recovered clock
// [R3] four-lane bonded: write on own bonded clock
// [R4] eight-lane bonded: write on master bonded clock
// [R5] byte deserializer halves the selected write clock
// [R6] user read clock has zero offset
// [R7] rate mismatch gives flagged overflow or underrun
// [R8] read driver is a listed, ungated clock
// [R9] one driver may serve many channels
// [R10] enabled user read clock overrides automatic choice
// [R11] automatic read clock follows channel configuration
// [R12] dual-clock FIFO keeps order, read-side timed
`ifndef RPC_MAP_VH
`define RPC_MAP_VH

// register bus shape
`define RPC_ADDR_W        4
`define RPC_BUS_W         32

// register offsets (byte addresses)
`define RPC_OFF_CTRL      4'h0
`define RPC_OFF_STATUS    4'h4

// control register fields
`define RPC_CTRL_BOND_LO  0
`define RPC_CTRL_BOND_HI  1
`define RPC_CTRL_RMATCH   2
`define RPC_CTRL_BDESER   3
`define RPC_CTRL_USERRD   4
`define RPC_CTRL_ENABLE   5
`define RPC_CTRL_W        6
`define RPC_CTRL_RST      6'h00

// bonding modes held in the control register
`define RPC_BOND_NONE     2'h0
`define RPC_BOND_X4       2'h1
`define RPC_BOND_X8       2'h2

// status register fields
`define RPC_ST_OVF        0
`define RPC_ST_UNF        1
`define RPC_ST_FULL       2
`define RPC_ST_EMPTY      3
`define RPC_ST_WACT       4
`define RPC_ST_RACT       5
`define RPC_ST_LVL_LO     8
`define RPC_ST_WSEL_LO    12
`define RPC_ST_RSEL_LO    16

// clock source indexes
`define RPC_NCLK          5
`define RPC_SRC_TX        3'h0
`define RPC_SRC_RX        3'h1
`define RPC_SRC_CORE4     3'h2
`define RPC_SRC_CORE8     3'h3
`define RPC_SRC_USER      3'h4

// word sizes and FIFO depth
`define RPC_DATA_W        16
`define RPC_STAT_W        4
`define RPC_AW            3
`define RPC_DEPTH         8

// clock activity timeout
`define RPC_CLK_NS        10
`define RPC_ACT_TMO_NS    2000
`define RPC_ACT_TMO_CYC   8'hC8  // 2000 ns of 10 ns clocks, at watchdog width
`define RPC_ACT_W         8

`endif

// [test/rpc_clk_src.sv]
/* link clock driver for the fabric side: n rising edges per request.
   assumes requests come only while o_busy is low. */
`timescale 1ns/1ps
module rpc_clk_src #(
  parameter HALF = 5
) (
  input  wire       i_clk,
  input  wire       i_arst_n,
  input  wire       i_go,
  input  wire [3:0] i_n,
  output reg        o_pclk,
  output wire       o_busy
);
  reg [3:0] left_q;
  reg [7:0] cnt_q;
  assign o_busy = (left_q != 4'h0) | o_pclk;
  // fixed-rate clock that runs only for a burst, low between bursts
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      left_q <= 4'h0;
      cnt_q <= 8'h0;
      o_pclk <= 1'b0;
    end else if (i_go) begin
      left_q <= i_n;
      cnt_q <= 8'h0;
    end else if (cnt_q == HALF - 1) begin
      cnt_q <= 8'h0;
      o_pclk <= !o_pclk && (left_q != 4'h0);
      if (!o_pclk && (left_q != 4'h0)) left_q <= left_q - 4'h1;
    end else if (o_busy) begin
      cnt_q <= cnt_q + 8'h1;
    end
  end
endmodule // rpc_clk_src

// [test/rpc_fifo_clk_monitor.sv]
/* port checker for the receive FIFO block.
   assumes it is bound to rpc_fifo_clk. */
`timescale 1ns/1ps
module rpc_fifo_clk_monitor (
  input wire        i_clk,
  input wire        i_arst_n,
  input wire [3:0]  i_addr,
  input wire        i_rd,
  input wire [31:0] o_rdata,
  input wire        i_tx_pclk,
  input wire        i_rx_pclk,
  input wire        i_core_clk_x4,
  input wire        i_core_clk_x8,
  input wire        i_user_rdclk,
  input wire [15:0] o_rd_data,
  input wire [3:0]  o_rd_status,
  input wire        o_rd_valid,
  input wire        o_fifo_err
);
  reg  [4:0] pin_q;
  reg  [6:0] rh_q;
  wire [4:0] pins = {i_tx_pclk, i_rx_pclk, i_core_clk_x4, i_core_clk_x8, i_user_rdclk};
  wire       st_rd = rh_q[6];
  // history of link pin rises
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_q <= 5'h00;
      rh_q <= 7'h00;
    end else begin
      pin_q <= pins;
      rh_q <= {i_rd && (i_addr == 4'h4), rh_q[4:0], |(pins & ~pin_q)};
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not idle");
  a_valid_pulse: assert property (o_rd_valid |=> !o_rd_valid)
    else $error("pop pulse too long");
  a_head_hold: assert property (!o_rd_valid |-> $stable({o_rd_status, o_rd_data}))
    else $error("head moved without pop");
  a_pop_cause: assert property (o_rd_valid |-> rh_q[5:2] != 4'h0)
    else $error("pop without a clock rise");
  a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) != 4'h0
    && $past(i_addr) != 4'h4 |-> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_resv: assert property ($past(i_rd) && $past(i_addr) == 4'h0
    |-> o_rdata[31:6] == 26'h0)
    else $error("ctrl spare bits set");
  a_level_flags: assert property (st_rd |-> o_rdata[11:8] <= 4'h8
    && o_rdata[2] == (o_rdata[11:8] == 4'h8) && o_rdata[3] == (o_rdata[11:8] == 4'h0))
    else $error("level and flags disagree");
  a_sel_follow: assert property (st_rd |-> o_rdata[14:12] <= 3'h3
    && (o_rdata[18:16] == 3'h4 || o_rdata[18:16] == o_rdata[14:12]))
    else $error("read source not user or write source");
  c_pop: cover property (o_rd_valid);
  c_err: cover property (o_fifo_err);
  c_full: cover property (st_rd && o_rdata[2]);
endmodule // rpc_fifo_clk_monitor
bind rpc_fifo_clk rpc_fifo_clk_monitor u_rpc_fifo_clk_monitor (.i_clk(i_clk),
  .i_arst_n(i_arst_n), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_tx_pclk(i_tx_pclk), .i_rx_pclk(i_rx_pclk), .i_core_clk_x4(i_core_clk_x4),
  .i_core_clk_x8(i_core_clk_x8), .i_user_rdclk(i_user_rdclk), .o_rd_data(o_rd_data),
  .o_rd_status(o_rd_status), .o_rd_valid(o_rd_valid), .o_fifo_err(o_fifo_err));

// [test/rpc_fifo_clk_tb.sv]
/* self-checking bench for rpc_fifo_clk.
   assumes two rpc_clk_src drivers: write pins and user read clock. */
`timescale 1ns/1ps
module rpc_fifo_clk_tb;
  reg          i_clk = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, rd_seen = 1'b0;
  reg  [3:0]   i_addr = 4'h0, i_rx_status = 4'h0, n = 4'h0;
  reg  [31:0]  i_wdata = 32'h0;
  reg  [15:0]  i_rx_data = 16'h0;
  reg  [2:0]   wsel = 3'h0;
  reg  [1:0]   go = 2'h0;
  wire         wclk, uclk, wbusy, ubusy, o_rd_valid, o_fifo_err;
  wire [31:0]  o_rdata;
  wire [15:0]  o_rd_data;
  wire [3:0]   o_rd_status;
  logic [31:0] eq[$], mq[$], dq[$];
  int          miscompares = 0, check_count = 0, lvl, i;
  rpc_clk_src u_rpc_clk_src (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_go(go[0]), .i_n(n),
    .o_pclk(wclk), .o_busy(wbusy));
  rpc_clk_src u_rpc_clk_src_rd (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_go(go[1]), .i_n(n),
    .o_pclk(uclk), .o_busy(ubusy));
  rpc_fifo_clk u_rpc_fifo_clk (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_tx_pclk(wclk & (wsel == 3'h0)), .i_rx_pclk(wclk & (wsel == 3'h1)),
    .i_core_clk_x4(wclk & (wsel == 3'h2)), .i_core_clk_x8(wclk & (wsel == 3'h3)),
    .i_user_rdclk(uclk), .i_rx_data(i_rx_data), .i_rx_status(i_rx_status),
    .o_rd_data(o_rd_data), .o_rd_status(o_rd_status), .o_rd_valid(o_rd_valid),
    .o_fifo_err(o_fifo_err));
  initial forever #5 i_clk = ~i_clk;
  task check(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task print_verdict;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watcher: register answers and popped words against the oldest note
  always @(posedge i_clk) begin
    rd_seen <= i_rd;
    if (rd_seen) check("rdata", o_rdata & mq.pop_front(), eq.pop_front());
    if (o_rd_valid === 1'b1)
      check("word", {o_rd_status, o_rd_data}, dq.size() ? dq.pop_front() : 32'hX);
  end
  task wreg(input [3:0] a, input [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task rreg(input [3:0] a, input [31:0] e, m);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    eq.push_back(e);
    mq.push_back(m);
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask
  // k 0: write pin edges with a fresh word; k 1: user read clock edges
  task burst(input int k, input [3:0] cnt, input bit keep);
    int t;
    logic [31:0] r;
    r = $urandom & 32'hFFFFF;
    @(posedge i_clk);
    go[k] <= 1'b1;
    n <= cnt;
    if (k == 0) {i_rx_status, i_rx_data} <= r[19:0];
    if (k == 0 && keep) dq.push_back(r);
    @(posedge i_clk);
    go <= 2'h0;
    @(posedge i_clk);
    for (t = 0; t < 300 && (wbusy || ubusy); t++) @(posedge i_clk);
    if (t == 300) begin
      miscompares++;
      print_verdict();
    end
    repeat (8) @(posedge i_clk);
  endtask
  initial begin
    void'($urandom(40));
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rreg(4'h0, 32'h0, 32'hFFFFFFFF);
    rreg(4'h4, 32'h8, 32'hF0F);
    wreg(4'hC, 32'h3F);
    rreg(4'hC, 32'h0, 32'hFFFFFFFF);
    rreg(4'h0, 32'h0, 32'hFFFFFFFF);
    // every bond, matcher and user clock setting
    for (i = 0; i < 32; i++) begin
      lvl = (i[1:0] == 2'h1) ? 2 : (i[1:0] == 2'h2) ? 3 : i[2] ? 0 : 1;
      wreg(4'h0, 32'h20 | i);
      rreg(4'h4, ((i[4] ? 4 : lvl) << 16) | (lvl << 12), 32'h77000);
    end
    // transmit clock writes, user clock drains in order
    wreg(4'h0, 32'h34);
    for (i = 0; i < 5; i++) burst(0, 1, 1);
    wsel <= 3'h1;
    burst(0, 2, 0);
    rreg(4'h4, 32'h500, 32'hF0F);
    burst(1, 5, 0);
    burst(1, 1, 0);
    check("err", o_fifo_err, 1'b1);
    rreg(4'h4, 32'hA, 32'hF0F);
    wreg(4'h4, 32'h3);
    rreg(4'h4, 32'h8, 32'hF0F);
    // recovered clock overfills the buffer
    wreg(4'h0, 32'h30);
    for (i = 0; i < 9; i++) burst(0, 1, i < 8);
    rreg(4'h4, 32'h805, 32'hF0F);
    burst(1, 8, 0);
    // automatic read clock: one tx pin writes and reads, one word in flight
    wreg(4'h4, 32'h3);
    wreg(4'h0, 32'h24);
    wsel <= 3'h0;
    for (i = 0; i < 3; i++) burst(0, 1, 1);
    wreg(4'h0, 32'h34);
    burst(1, 1, 0);
    rreg(4'h4, 32'h8, 32'hF0F);
    check("err", o_fifo_err, 1'b0);
    // bonded clock halved by the byte deserializer
    wreg(4'h4, 32'h3);
    wreg(4'h0, 32'h19);
    wreg(4'h0, 32'h39);
    wsel <= 3'h2;
    burst(0, 2, 1);
    burst(0, 1, 0);
    burst(0, 1, 1);
    rreg(4'h4, 32'h200, 32'hF0F);
    burst(1, 2, 0);
    burst(0, 2, 0);
    wreg(4'h0, 32'h0);
    rreg(4'h4, 32'h8, 32'hF0F);
    repeat (10) @(posedge i_clk);
    check("left", dq.size() + eq.size(), 0);
    print_verdict();
  end
endmodule // rpc_fifo_clk_tb
